// [amr_conv_ctrl.sv]
// module: conversion mode, trigger, result and accumulator logic with wishbone registers
//
// Function
// - convert chosen external or internal source, 12-bit
// - internal source disconnects external channel input
// - mode from group count and two-channel bit
// - two-channel mode uses dedicated channel selects
// - automatic group starts on selected trigger
// - group of 1,2,4,8,16 conversions, or of channel pairs in two-channel mode
// - format bit selects left or right alignment
// - unused result bits read zero
// - disabled converter keeps result pair
// - nonzero group count forces right alignment
// - automatic mode keeps per-channel sum buffers
// - start bit low-high-low begins one conversion in manual mode
// - busy flag set at start, cleared at end
// - two-bit field picks automatic trigger source
// - trigger during a conversion sets repeat flag, sticky
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
module amr_conv_ctrl
(
  input  wire logic        mclk,
  input  wire logic        reset,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  output logic             irq,
  // trigger sources
  input  wire logic        pwmRise,
  input  wire logic        timerOverflow,
  // converter core and multiplexer
  output logic             convStart,
  output logic             convPowerOn,
  output logic      [2:0]  sourceSelect,
  output logic      [3:0]  externalChannel,
  output logic             externalConnect,
  output logic      [7:0]  analogConfig,
  input  wire logic        convDone,
  input  wire logic [11:0] convData
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]          ctrl0;
    logic [7:0]          ctrl1;
    logic [7:0]          ctrl2;
    logic [7:0]          blank;
    logic [7:0]          ach1;
    logic [7:0]          ach2;
    logic [7:0]          interval;
    logic [11:0]         result;
    logic [15:0]         sum1;
    logic [15:0]         sum2;
    logic [4:0]          left;
    logic                secondCh;
    logic                startArmed;
    logic                swTrigPrev;
    amr_pkg::amr_state_t state;
    logic                start;
    logic [amr_pkg::IRQ_W-1:0] irqStat;
    logic [amr_pkg::IRQ_W-1:0] irqMask;
    logic                ack;
    logic                err;
    logic [31:0]         rdata;
  } amr_state_reg_t;

  amr_state_reg_t s_r;
  amr_state_reg_t s_nxt;

  amr_pkg::amr_mode_t mode;
  logic               busAccess;
  logic               wrStrobe;
  logic               rdStrobe;
  logic [3:0]         idx;
  logic               mapped;
  logic [7:0]         wbyte;
  logic               trigger;
  logic               swRise;
  logic [4:0]         groupLen;
  logic [7:0]         resHi;
  logic [7:0]         resLo;
  logic               fmtRight;
  logic [7:0]         rdByte;

  // ==========================================================
  // decoding
  always_comb
  begin
    idx       = adr_i[5:2];
    mapped    = (idx <= amr_pkg::IDX_IRQ_MASK);
    busAccess = cyc_i && stb_i && !s_r.ack && !s_r.err;
    wrStrobe  = busAccess && we_i && sel_i[0] && mapped;
    rdStrobe  = busAccess && !we_i && mapped;
    wbyte     = dat_i[7:0];
    if (s_r.ctrl2[2:0] == 3'h0)
      mode = amr_pkg::AMR_MANUAL;
    else if (s_r.ach1[amr_pkg::ACH1_TWOCH])
      mode = amr_pkg::AMR_AUTO2;
    else
      mode = amr_pkg::AMR_AUTO1;
    // group length 1,2,4,8,16 (codes 5 to 7 use 16)
    unique case (s_r.ctrl2[2:0])
      3'h1:    groupLen = 5'd1;
      3'h2:    groupLen = 5'd2;
      3'h3:    groupLen = 5'd4;
      3'h4:    groupLen = 5'd8;
      default: groupLen = 5'd16;
    endcase
    swRise = s_r.blank[amr_pkg::BLANK_SWTRIG] && !s_r.swTrigPrev;
    unique case (s_r.ctrl2[7:6])
      amr_pkg::TRG_PWM:     trigger = pwmRise;
      amr_pkg::TRG_TMR_OVP: trigger = timerOverflow;
      amr_pkg::TRG_TMR_SW:  trigger = timerOverflow;
      default:              trigger = swRise;
    endcase
    // hardware forces right alignment in automatic modes
    fmtRight = s_r.ctrl0[amr_pkg::CTRL0_FORMAT] || (mode != amr_pkg::AMR_MANUAL);
    if (fmtRight)
    begin
      resHi = {4'h0, s_r.result[11:8]};
      resLo = s_r.result[7:0];
    end
    else
    begin
      resHi = s_r.result[11:4];
      resLo = {s_r.result[3:0], 4'h0};
    end
  end

  // ==========================================================
  // register readback
  always_comb
  begin
    rdByte = 8'h00;
    unique case (idx)
      amr_pkg::IDX_RES_LO:   rdByte = resLo;
      amr_pkg::IDX_RES_HI:   rdByte = resHi;
      amr_pkg::IDX_SUM1_HI:  rdByte = s_r.sum1[15:8];
      amr_pkg::IDX_SUM1_LO:  rdByte = s_r.sum1[7:0];
      amr_pkg::IDX_SUM2_HI:  rdByte = s_r.sum2[15:8];
      amr_pkg::IDX_SUM2_LO:  rdByte = s_r.sum2[7:0];
      amr_pkg::IDX_CTRL0:    rdByte = {s_r.ctrl0[7], s_r.state != amr_pkg::AMR_IDLE, s_r.ctrl0[5],
                                       fmtRight, s_r.ctrl0[3:0]};
      amr_pkg::IDX_CTRL1:    rdByte = s_r.ctrl1;
      amr_pkg::IDX_CTRL2:    rdByte = s_r.ctrl2;
      amr_pkg::IDX_BLANK:    rdByte = s_r.blank;
      amr_pkg::IDX_ACH1:     rdByte = s_r.ach1;
      amr_pkg::IDX_ACH2:     rdByte = s_r.ach2;
      amr_pkg::IDX_INTERVAL: rdByte = s_r.interval;
      amr_pkg::IDX_IRQ_STAT: rdByte = {5'h00, s_r.irqStat};
      amr_pkg::IDX_IRQ_MASK: rdByte = {5'h00, s_r.irqMask};
      default:               rdByte = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    s_nxt.ack   = busAccess && mapped;
    s_nxt.err   = busAccess && !mapped;
    s_nxt.swTrigPrev = s_r.blank[amr_pkg::BLANK_SWTRIG];
    if (rdStrobe)
      s_nxt.rdata = {24'h000000, rdByte};

    // software writes; read-only bits are protected by masks
    if (wrStrobe)
    begin
      unique case (idx)
        amr_pkg::IDX_CTRL0:    s_nxt.ctrl0 = wbyte & amr_pkg::CTRL0_WMASK;
        amr_pkg::IDX_CTRL1:    s_nxt.ctrl1 = wbyte;
        // software may only clear the repeat flag
        amr_pkg::IDX_CTRL2:    s_nxt.ctrl2 = (wbyte & amr_pkg::CTRL2_WMASK)
                                             | (wbyte & s_r.ctrl2 & 8'h10);
        amr_pkg::IDX_BLANK:    s_nxt.blank = wbyte & amr_pkg::BLANK_WMASK;
        amr_pkg::IDX_ACH1:     s_nxt.ach1 = wbyte & amr_pkg::ACH1_WMASK;
        amr_pkg::IDX_ACH2:     s_nxt.ach2 = wbyte & amr_pkg::ACH2_WMASK;
        amr_pkg::IDX_INTERVAL: s_nxt.interval = wbyte & amr_pkg::INTV_WMASK;
        amr_pkg::IDX_IRQ_MASK: s_nxt.irqMask = wbyte[amr_pkg::IRQ_W-1:0];
        default:               s_nxt.ctrl1 = s_r.ctrl1;
      endcase
    end
    // read of status clears it; new events below win
    if (rdStrobe && idx == amr_pkg::IDX_IRQ_STAT)
      s_nxt.irqStat = '0;

    // software trigger rise clears repeat flag, unless it is the selected trigger during a conversion
    if (swRise)
      s_nxt.ctrl2[amr_pkg::CTRL2_REPEAT] = 1'b0;

    // falling edge of armed start bit in manual mode
    if (s_r.ctrl0[amr_pkg::CTRL0_START] && mode == amr_pkg::AMR_MANUAL)
      s_nxt.startArmed = 1'b1;
    if (mode != amr_pkg::AMR_MANUAL)
      s_nxt.startArmed = 1'b0;

    unique case (s_r.state)
      amr_pkg::AMR_IDLE:
      begin
        // manual conversion on software start only; a start sequence seen
        // while disabled is dropped, else it would fire once enable is set later
        if (mode == amr_pkg::AMR_MANUAL && s_r.startArmed && !s_r.ctrl0[amr_pkg::CTRL0_START])
        begin
          s_nxt.startArmed = 1'b0;
          // a disable written in this very cycle also suppresses the start
          if (s_r.ctrl0[amr_pkg::CTRL0_ENABLE] && s_nxt.ctrl0[amr_pkg::CTRL0_ENABLE])
          begin
            s_nxt.start    = 1'b1;
            s_nxt.state    = amr_pkg::AMR_CONV;
            s_nxt.left     = 5'd1;
            s_nxt.secondCh = 1'b0;
          end
        end
        else if (mode != amr_pkg::AMR_MANUAL && trigger && s_r.ctrl0[amr_pkg::CTRL0_ENABLE]
                 && s_nxt.ctrl0[amr_pkg::CTRL0_ENABLE])
        begin
          s_nxt.sum1     = 16'h0000;
          s_nxt.sum2     = 16'h0000;
          s_nxt.left     = groupLen;
          s_nxt.secondCh = 1'b0;
          s_nxt.start    = 1'b1;
          s_nxt.state    = amr_pkg::AMR_CONV;
        end
      end
      amr_pkg::AMR_CONV:
      begin
        // trigger during conversion marks a repeat
        if (mode != amr_pkg::AMR_MANUAL && trigger)
        begin
          s_nxt.ctrl2[amr_pkg::CTRL2_REPEAT] = 1'b1;
          s_nxt.irqStat[amr_pkg::IRQ_REPEAT] = 1'b1;
        end
        if (!s_r.ctrl0[amr_pkg::CTRL0_ENABLE])
          s_nxt.state = amr_pkg::AMR_IDLE;
        else if (convDone)
        begin
          s_nxt.result = convData;
          s_nxt.irqStat[amr_pkg::IRQ_DONE] = 1'b1;
          if (mode != amr_pkg::AMR_MANUAL)
          begin
            if (s_r.secondCh)
              s_nxt.sum2 = s_r.sum2 + {4'h0, convData};
            else
              s_nxt.sum1 = s_r.sum1 + {4'h0, convData};
          end
          // a pair counts as one group step in two-channel mode
          if (mode == amr_pkg::AMR_AUTO2 && !s_r.secondCh)
          begin
            s_nxt.secondCh = 1'b1;
            s_nxt.state    = amr_pkg::AMR_WAIT;
          end
          else if (s_r.left > 5'd1)
          begin
            s_nxt.left     = s_r.left - 5'd1;
            s_nxt.secondCh = 1'b0;
            s_nxt.state    = amr_pkg::AMR_WAIT;
          end
          else
          begin
            // busy drops after the last conversion
            s_nxt.state = amr_pkg::AMR_IDLE;
            if (mode != amr_pkg::AMR_MANUAL)
              s_nxt.irqStat[amr_pkg::IRQ_GROUP] = 1'b1;
          end
        end
      end
      amr_pkg::AMR_WAIT:
      begin
        // one idle cycle between group conversions, still busy
        // never start an unpowered core, even if disable lands in this cycle
        s_nxt.start = s_r.ctrl0[amr_pkg::CTRL0_ENABLE] && s_nxt.ctrl0[amr_pkg::CTRL0_ENABLE];
        s_nxt.state = s_nxt.start ? amr_pkg::AMR_CONV : amr_pkg::AMR_IDLE;
      end
      default: s_nxt.state = amr_pkg::AMR_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_r       <= '0;
      s_r.state <= amr_pkg::AMR_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  always_comb
  begin
    dat_o       = s_r.rdata;
    ack_o       = s_r.ack;
    err_o       = s_r.err;
    irq         = |(s_r.irqStat & s_r.irqMask);
    // busy starts with the start pulse
    convStart   = s_r.start;
    convPowerOn = s_r.ctrl0[amr_pkg::CTRL0_ENABLE];
    analogConfig = s_r.ctrl1;
    if (mode == amr_pkg::AMR_AUTO2)
    begin
      sourceSelect    = s_r.secondCh ? (s_r.ach2[4] ? amr_pkg::SRC_VSS : amr_pkg::SRC_EXT)
                                     : (s_r.ach1[4] ? amr_pkg::SRC_VSS : amr_pkg::SRC_EXT);
      externalChannel = s_r.secondCh ? s_r.ach2[3:0] : s_r.ach1[3:0];
    end
    else
    begin
      sourceSelect    = s_r.ctrl1[7:5];
      externalChannel = s_r.ctrl0[3:0];
    end
    // internal source opens the external switch
    externalConnect = !(sourceSelect >= 3'h1 && sourceSelect <= amr_pkg::SRC_VSS)
                      && externalChannel <= 4'ha;
  end

endmodule // amr_conv_ctrl

// [amr_conv_ctrl_properties.sv]
// checker: port relations of the conversion control block
module amr_conv_ctrl_properties
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        convStart,
  input wire logic        convPowerOn,
  input wire logic [2:0]  sourceSelect,
  input wire logic [3:0]  externalChannel,
  input wire logic        externalConnect
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // analog routing
  internal_disconnect_a: assert property (
    sourceSelect inside {[3'h1:3'h4]} |-> !externalConnect) else $error("external input left on");
  ext_connect_a: assert property (
    !(sourceSelect inside {[3'h1:3'h4]}) && externalChannel <= 4'ha |-> externalConnect)
    else $error("external input not connected");
  bad_channel_a: assert property (
    externalChannel > 4'ha |-> !externalConnect) else $error("floating channel connected");

  // ==========================================================
  // conversion start; a start never reaches a powered-off core
  start_pulse_a: assert property (convStart |=> !convStart) else $error("start longer than one cycle");
  start_powered_a: assert property (convStart |-> convPowerOn) else $error("start while disabled");
  start_prior_power_a: assert property (
    $rose(convStart) |-> $past(convPowerOn)) else $error("start in enable cycle");

  // ==========================================================
  // register reads
  upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
  bus_answer_a: assert property (
    cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o) else $error("bus answer missing");

  cover property (convStart);
  cover property (!externalConnect);
  cover property (err_o);
endmodule // amr_conv_ctrl_properties

bind amr_conv_ctrl amr_conv_ctrl_properties chk
(
  .mclk(mclk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .convStart(convStart), .convPowerOn(convPowerOn), .sourceSelect(sourceSelect),
  .externalChannel(externalChannel), .externalConnect(externalConnect)
);

// [amr_core_model.sv]
// partner model: converter core answering the latest start after a fixed delay; a start during the delay restarts it
module amr_core_model
#(
  parameter int DLY = 8
)
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        convStart,
  input  wire logic [2:0]  sourceSelect,
  input  wire logic [3:0]  externalChannel,
  output logic             convDone,
  output logic      [11:0] convData
);
  timeunit 1ns;
  timeprecision 1ns;
  int          cnt = 0;
  logic [11:0] val = 12'h000;

  always_ff @(posedge mclk)
  begin
    convDone <= 1'b0;
    convData <= ~val; // not valid outside done, so never the last value
    if (reset)
      cnt <= 0;
    else if (convStart)
    begin
      cnt <= DLY;
      val <= {sourceSelect, externalChannel, 5'h15};
    end
    else if (cnt == 1)
    begin
      cnt <= 0;
      convDone <= 1'b1;
      convData <= val;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule // amr_core_model

// [amr_pkg.sv]
// package: register map, field layout and constants for the conversion control block
package amr_pkg;

  // ==========================================================
  // register word indices (byte address = index * 4)
  localparam logic [3:0] IDX_RES_LO   = 4'h0;
  localparam logic [3:0] IDX_RES_HI   = 4'h1;
  localparam logic [3:0] IDX_SUM1_HI  = 4'h2;
  localparam logic [3:0] IDX_SUM1_LO  = 4'h3;
  localparam logic [3:0] IDX_SUM2_HI  = 4'h4;
  localparam logic [3:0] IDX_SUM2_LO  = 4'h5;
  localparam logic [3:0] IDX_CTRL0    = 4'h6;
  localparam logic [3:0] IDX_CTRL1    = 4'h7;
  localparam logic [3:0] IDX_CTRL2    = 4'h8;
  localparam logic [3:0] IDX_BLANK    = 4'h9;
  localparam logic [3:0] IDX_ACH1     = 4'ha;
  localparam logic [3:0] IDX_ACH2     = 4'hb;
  localparam logic [3:0] IDX_INTERVAL = 4'hc;
  localparam logic [3:0] IDX_IRQ_STAT = 4'hd;
  localparam logic [3:0] IDX_IRQ_MASK = 4'he;

  // ==========================================================
  // field positions
  localparam int CTRL0_START   = 7;
  localparam int CTRL0_BUSY    = 6;
  localparam int CTRL0_ENABLE  = 5;
  localparam int CTRL0_FORMAT  = 4;
  localparam int CTRL2_REPEAT  = 4;
  localparam int BLANK_SWTRIG  = 7;
  localparam int ACH1_TWOCH    = 5;

  // writable masks per register
  localparam logic [7:0] CTRL0_WMASK = 8'hbf;
  localparam logic [7:0] CTRL2_WMASK = 8'hc7;
  localparam logic [7:0] BLANK_WMASK = 8'h9f;
  localparam logic [7:0] ACH1_WMASK  = 8'h3f;
  localparam logic [7:0] ACH2_WMASK  = 8'h1f;
  localparam logic [7:0] INTV_WMASK  = 8'h0f;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // source codes
  localparam logic [2:0] SRC_EXT     = 3'h0;
  localparam logic [2:0] SRC_VSS     = 3'h4;

  // trigger select codes
  localparam logic [1:0] TRG_PWM     = 2'h0;
  localparam logic [1:0] TRG_TMR_OVP = 2'h1;
  localparam logic [1:0] TRG_TMR_SW  = 2'h2;
  localparam logic [1:0] TRG_SW      = 2'h3;

  // interrupt status bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_GROUP  = 1;
  localparam int IRQ_REPEAT = 2;
  localparam int IRQ_W      = 3;

  localparam logic [3:0] NO_EXT_CH   = 4'hf;

  typedef enum logic [1:0] {AMR_MANUAL, AMR_AUTO1, AMR_AUTO2} amr_mode_t;
  typedef enum logic [1:0] {AMR_IDLE, AMR_CONV, AMR_WAIT} amr_state_t;

endpackage : amr_pkg

// [test_amr_conv_ctrl.sv]
// testbench: register level tests of the conversion control block
module test_amr_conv_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset, cyc, stb, we, ack, err, irq, pwm, tmr, start, power, extOn, done;
  logic [5:0] adr;
  logic [31:0] dout, din;
  logic [2:0] src;
  logic [3:0] ch;
  logic [7:0] cfg, v;
  logic [11:0] data;
  logic e;
  int failures = 0, comparisons = 0, starts = 0, n;

  amr_conv_ctrl uut (.mclk(mclk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(dout), .dat_o(din), .ack_o(ack), .err_o(err), .irq(irq), .pwmRise(pwm),
    .timerOverflow(tmr), .convStart(start), .convPowerOn(power), .sourceSelect(src),
    .externalChannel(ch), .externalConnect(extOn), .analogConfig(cfg), .convDone(done), .convData(data));
  amr_core_model core (.mclk(mclk), .reset(reset), .convStart(start), .sourceSelect(src),
    .externalChannel(ch), .convDone(done), .convData(data));

  // ==========================================================
  // clock, start counter, watchdog
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (start === 1'b1) starts <= starts + 1;
  initial
  begin
    #500000;
    failures++;
    end_of_test();
  end

  task automatic end_of_test();
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    comparisons++;
    if (got !== ex)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // ==========================================================
  // one classic cycle; held until ack or err is sampled
  task automatic bus(logic w, logic [3:0] idx, logic [7:0] wd);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    dout <= {24'h0, wd};
    do @(posedge mclk); while (ack !== 1'b1 && err !== 1'b1);
    v = din[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(logic [3:0] idx, logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(logic [3:0] idx, logic [7:0] ex, string nm);
    bus(1'b0, idx, 8'h00);
    chk(nm, ex, v);
  endtask
  task automatic waitbusy(logic b);
    int k = 0;
    do begin bus(1'b0, amr_pkg::IDX_CTRL0, 8'h00); k++; end while (v[amr_pkg::CTRL0_BUSY] !== b && k < 30);
    chk("busy flag", b, v[amr_pkg::CTRL0_BUSY]);
  endtask
  task automatic manual(logic [7:0] c);
    wr(amr_pkg::IDX_CTRL0, c | 8'h80);
    wr(amr_pkg::IDX_CTRL0, c);
    waitbusy(1'b1);
    waitbusy(1'b0);
  endtask
  task automatic swtrig();
    wr(amr_pkg::IDX_BLANK, 8'h00);
    wr(amr_pkg::IDX_BLANK, 8'h80);
  endtask
  task automatic pulse(logic p);
    @(posedge mclk);
    if (p) pwm <= 1'b1; else tmr <= 1'b1;
    @(posedge mclk);
    pwm <= 1'b0;
    tmr <= 1'b0;
  endtask
  task automatic waitirq(logic [7:0] st);
    int k = 0;
    while (irq !== 1'b1 && k < 300) begin @(posedge mclk); k++; end
    rdc(amr_pkg::IDX_IRQ_STAT, st, "irq status");
    chk("irq after clear", 1'b0, irq);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {reset, cyc, stb, we, pwm, tmr, adr, dout} <= {1'b1, 43'h0};
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rdc(amr_pkg::IDX_CTRL0, 8'h00, "ctrl0 reset");
    rdc(amr_pkg::IDX_CTRL2, 8'h00, "ctrl2 reset");
    wr(amr_pkg::IDX_IRQ_MASK, 8'h02);
    manual(8'h23);
    rdc(amr_pkg::IDX_RES_HI, 8'h07, "left high");
    rdc(amr_pkg::IDX_RES_LO, 8'h50, "left low");
    wr(amr_pkg::IDX_CTRL1, 8'h80);
    chk("analog config", 16'h0080, {8'h00, cfg});
    manual(8'h33);
    chk("external connect", 1'b0, extOn);
    rdc(amr_pkg::IDX_RES_HI, 8'h08, "right high");
    rdc(amr_pkg::IDX_RES_LO, 8'h75, "right low");
    n = starts;
    wr(amr_pkg::IDX_CTRL0, 8'h93);
    wr(amr_pkg::IDX_CTRL0, 8'h13);
    chk("power off", 1'b0, power);
    repeat (20) @(posedge mclk);
    chk("no start disabled", 16'(n), 16'(starts));
    // start on channel 5, then disable before the core answers
    wr(amr_pkg::IDX_CTRL0, 8'hb5);
    wr(amr_pkg::IDX_CTRL0, 8'h35);
    chk("power on", 1'b1, power);
    wr(amr_pkg::IDX_CTRL0, 8'h15);
    repeat (20) @(posedge mclk);
    chk("aborted start", 16'(n + 1), 16'(starts));
    rdc(amr_pkg::IDX_RES_LO, 8'h75, "kept low");
    rdc(amr_pkg::IDX_RES_HI, 8'h08, "kept high");
    wr(amr_pkg::IDX_CTRL1, 8'h00);
    wr(amr_pkg::IDX_CTRL0, 8'h29);
    wr(amr_pkg::IDX_CTRL2, 8'hc2);
    rdc(amr_pkg::IDX_CTRL0, 8'h39, "forced format");
    n = starts;
    swtrig();
    waitirq(8'h03);
    chk("group starts", 16'(n + 2), 16'(starts));
    rdc(amr_pkg::IDX_SUM1_HI, 8'h02, "sum1 high");
    rdc(amr_pkg::IDX_SUM1_LO, 8'h6a, "sum1 low");
    rdc(amr_pkg::IDX_RES_HI, 8'h01, "auto high");
    rdc(amr_pkg::IDX_RES_LO, 8'h35, "auto low");
    wr(amr_pkg::IDX_ACH1, 8'h25);
    wr(amr_pkg::IDX_ACH2, 8'h07);
    wr(amr_pkg::IDX_CTRL1, 8'h80);
    wr(amr_pkg::IDX_CTRL2, 8'hc1);
    swtrig();
    waitirq(8'h03);
    wr(amr_pkg::IDX_SUM1_LO, 8'hff);
    rdc(amr_pkg::IDX_SUM1_LO, 8'hb5, "pair sum1");
    rdc(amr_pkg::IDX_SUM2_HI, 8'h00, "pair sum2 high");
    rdc(amr_pkg::IDX_SUM2_LO, 8'hf5, "pair sum2");
    wr(amr_pkg::IDX_ACH1, 8'h00);
    for (int i = 1; i < 4; i++)
    begin
      wr(amr_pkg::IDX_CTRL2, {i[1:0], 6'h01});
      n = starts;
      if (i == 3) swtrig(); else pulse(1'b0);
      waitirq(8'h03);
      chk("trigger start", 16'(n + 1), 16'(starts));
    end
    wr(amr_pkg::IDX_CTRL2, 8'h01);
    pulse(1'b1);
    pulse(1'b1);
    waitirq(8'h07);
    rdc(amr_pkg::IDX_CTRL2, 8'h11, "repeat set");
    wr(amr_pkg::IDX_CTRL2, 8'h01);
    rdc(amr_pkg::IDX_CTRL2, 8'h01, "repeat cleared");
    wr(amr_pkg::IDX_CTRL2, 8'h11);
    rdc(amr_pkg::IDX_CTRL2, 8'h01, "repeat not set");
    // set the flag again, then let a software trigger rise clear it
    pulse(1'b1);
    pulse(1'b1);
    waitirq(8'h07);
    rdc(amr_pkg::IDX_CTRL2, 8'h11, "repeat set again");
    swtrig();
    rdc(amr_pkg::IDX_CTRL2, 8'h01, "repeat hw cleared");
    bus(1'b0, 4'hf, 8'h00);
    chk("unmapped error", 1'b1, e);
    end_of_test();
  end
endmodule // test_amr_conv_ctrl
